/* lbc_consts.svh */
`ifndef LBC_CONSTS_SVH
`define LBC_CONSTS_SVH
`define LBC_ADDR_W 30
`define LBC_DATA_W 32
`define LBC_LANES 4
`define LBC_IO_ADDR_MAX 30'h00003FFF
`define LBC_INVAL_LSB 2
`define LBC_CT_INTA 3'h0
`define LBC_CT_HALT 3'h1
`define LBC_CT_IORD 3'h2
`define LBC_CT_IOWR 3'h3
`define LBC_CT_CODE 3'h4
`define LBC_CT_RSVD 3'h5
`define LBC_CT_MEMRD 3'h6
`define LBC_CT_MEMWR 3'h7
`endif

/* lbc_pkg.sv */
package lbc_pkg;
  typedef enum logic [1:0] {
    LBC_IDLE = 2'b00,
    LBC_FIRST = 2'b01,
    LBC_WAIT = 2'b10,
    LBC_CHECK = 2'b11
  } lbc_state_t;
endpackage

/* lbc_if.sv */
`timescale 1ns/1ns
interface lbc_if;
  logic [29:0] word_address_lines_o;
  logic [29:0] word_address_lines_i;
  logic addr_oe;
  logic [3:0] byte_lane_enables_n;
  logic be_oe;
  logic [31:0] data_dev_o;
  logic [31:0] data_ext_o;
  logic data_dev_oe;
  logic data_ext_oe;
  logic [3:0] parity_dev_o;
  logic [3:0] parity_ext_o;
  logic [2:0] cycle_type;
  logic address_strobe_n;
  logic ctl_oe;
  logic lock_n;
  logic pseudo_lock_n;
  logic last_burst_transfer_n;
  logic ready_n;
  logic parity_error_status_n;
  logic address_float_request;
  logic hold_req;
  logic hold_ack;
  logic [31:0] data_bus_lines;
  logic [3:0] byte_parity_lines;
  assign data_bus_lines = data_dev_oe ? data_dev_o : (data_ext_oe ? data_ext_o : 32'hFFFFFFFF);
  assign byte_parity_lines = data_dev_oe ? parity_dev_o : (data_ext_oe ? parity_ext_o : 4'hF);
  modport dev (
    output word_address_lines_o, addr_oe, byte_lane_enables_n, be_oe, data_dev_o,
    output data_dev_oe, parity_dev_o, cycle_type, address_strobe_n, ctl_oe, lock_n,
    output pseudo_lock_n, last_burst_transfer_n, parity_error_status_n, hold_ack,
    input word_address_lines_i, data_bus_lines, byte_parity_lines, ready_n,
    input address_float_request, hold_req
  );
  modport ext (
    input word_address_lines_o, addr_oe, byte_lane_enables_n, be_oe, data_bus_lines,
    input byte_parity_lines, cycle_type, address_strobe_n, ctl_oe, lock_n, pseudo_lock_n,
    input last_burst_transfer_n, parity_error_status_n, hold_ack,
    output word_address_lines_i, data_ext_o, data_ext_oe, parity_ext_o, ready_n,
    output address_float_request, hold_req
  );
endinterface

/* lbc_parity.sv */
`timescale 1ns/1ns
// Even parity per byte: the parity bit makes each lane's ones count even
module lbc_parity (
  input wire logic [31:0] data,
  output logic [3:0] parity
);
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      assign parity[g] = ^data[8*g +: 8];
    end
  endgenerate
endmodule

/* lbc_device.sv */
`timescale 1ns/1ns
`include "lbc_consts.svh"
// What this block does
// [RL1] 4 GB memory, 64 KB I/O, word addresses
// [RL2] Active-low byte enable selects one lane
// [RL3] Accept invalidation line address on upper bits
// [RL4] Float address on hold; enables on bus hold
// [RL5] Data driven only for write data
// [RL6] Even parity per byte on writes
// [RL7] Far end returns even read parity
// [RL8] Parity status the clock after read ready; the code asserts it four clocks after ready
// [RL9] Check enabled bytes; skip interrupt acknowledge
// [RL10] Parity error only affects the status
// [RL11] Cycle type codes valid with strobe
// [RL12] Lock from first locked cycle to ready
// [RL13] Lock refuses bus hold, allows address hold
// [RL14] Locked reads never become line fills
// [RL15] Pseudo-lock for 64/128-bit multi-cycle transfers
// [RL16] Pseudo-lock refuses hold until last address
// [RL17] Pseudo-lock inverse of last, except FP write
// [RL18] Far end samples pseudo-lock at ready
// [RL19] Strobe only in first clock of cycle
// [RL20] Far end captures type after strobe
// [RL21] Ready ignored idle and in first clock
// [RL22] Cycle at least two clocks
// [RL23] All inputs registered on rising edge
module lbc_device
  import lbc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  lbc_if.dev bus,
  input wire logic req_valid,
  input wire logic [2:0] req_type,
  input wire logic [29:0] req_addr,
  input wire logic [3:0] req_be_n,
  input wire logic [31:0] req_wdata,
  input wire logic [1:0] req_count,
  input wire logic req_lock,
  input wire logic req_fp_write,
  output logic req_ready,
  output logic done_pulse,
  output logic [31:0] rdata,
  output logic parity_bad,
  output logic [29:0] inval_addr,
  output logic inval_valid
);
  lbc_state_t state_reg;
  logic [2:0] type_reg;
  logic [29:0] addr_reg;
  logic [3:0] be_n_reg;
  logic [31:0] wdata_reg;
  logic [1:0] left_reg;
  logic lock_reg, pseudo_lock_n_reg, fpw_reg, first_reg, check_reg, hold_reg;
  logic rdy_s1, rdy_s2, ah_s1, ah_s2, hr_s1, hr_s2, address_float_request_d;
  logic [31:0] d_s1, d_s2, d_cap;
  logic [3:0] p_s1, p_s2, p_cap, wpar, rpar;
  logic [29:0] a_s1, a_s2;
  logic is_read, rdy_ok;

  // ****************************************
  // Input synchronisers
  // ****************************************
  always_ff @(posedge clk) begin // [RL23]
    if (reset) begin
      // Ready idles high; hold requests idle low so no false edge follows reset
      {rdy_s1, rdy_s2, ah_s1, ah_s2, hr_s1, hr_s2, address_float_request_d} <= 7'h60;
      d_s1 <= 32'h0; d_s2 <= 32'h0; p_s1 <= 4'h0; p_s2 <= 4'h0;
      a_s1 <= 30'h0; a_s2 <= 30'h0;
    end else if (clk_en) begin
      rdy_s1 <= bus.ready_n; rdy_s2 <= rdy_s1;
      ah_s1 <= bus.address_float_request; ah_s2 <= ah_s1;
      hr_s1 <= bus.hold_req; hr_s2 <= hr_s1;
      d_s1 <= bus.data_bus_lines; d_s2 <= d_s1;
      p_s1 <= bus.byte_parity_lines; p_s2 <= p_s1;
      a_s1 <= bus.word_address_lines_i; a_s2 <= a_s1;
      address_float_request_d <= ah_s2;
    end
  end

  lbc_parity u_wpar (.data(wdata_reg), .parity(wpar)); // [RL6]
  lbc_parity u_rpar (.data(d_s2), .parity(rpar));

  assign is_read = ~type_reg[0];
  assign rdy_ok = (state_reg == LBC_WAIT) && !rdy_s2; // [RL21] [RL22]

  // ****************************************
  // Cycle sequencer
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= LBC_IDLE;
      type_reg <= `LBC_CT_MEMRD; addr_reg <= 30'h0; be_n_reg <= 4'hF;
      wdata_reg <= 32'h0; left_reg <= 2'h0; lock_reg <= 1'b0;
      pseudo_lock_n_reg <= 1'b0; fpw_reg <= 1'b0; first_reg <= 1'b0;
      check_reg <= 1'b0; hold_reg <= 1'b0;
      d_cap <= 32'h0; p_cap <= 4'h0;
    end else if (clk_en) begin
      check_reg <= 1'b0;
      case (state_reg)
        LBC_IDLE: begin
          // Hold granted only between cycles and never inside lock sequences
          hold_reg <= hr_s2 && !lock_reg && !pseudo_lock_n_reg; // [RL13] [RL16]
          if (req_valid && !(hr_s2 && !lock_reg && !pseudo_lock_n_reg) && req_type != `LBC_CT_RSVD) begin // [RL11]
            state_reg <= LBC_FIRST;
            type_reg <= req_type;
            // I/O space wraps within 64 KB
            addr_reg <= req_type[2] ? req_addr : (req_addr & `LBC_IO_ADDR_MAX); // [RL1]
            be_n_reg <= req_be_n; wdata_reg <= req_wdata;
            left_reg <= req_lock ? 2'h0 : req_count; // [RL14]
            lock_reg <= req_lock; // [RL12]
            pseudo_lock_n_reg <= !req_lock && req_count != 2'h0; // [RL15]
            fpw_reg <= req_fp_write && req_type == `LBC_CT_MEMWR;
            first_reg <= 1'b1;
          end else begin
            lock_reg <= lock_reg && req_lock; // [RL12]
          end
        end
        LBC_FIRST: state_reg <= LBC_WAIT; // [RL19]
        LBC_WAIT: if (rdy_ok) begin
          d_cap <= d_s2; p_cap <= p_s2 ^ rpar;
          check_reg <= is_read && type_reg != `LBC_CT_INTA; // [RL9]
          first_reg <= 1'b0;
          if (left_reg != 2'h0) begin
            left_reg <= left_reg - 2'h1;
            addr_reg <= addr_reg + 30'h1;
            state_reg <= LBC_FIRST;
            if (left_reg == 2'h1) pseudo_lock_n_reg <= 1'b0; // [RL16]
          end else begin
            state_reg <= LBC_IDLE;
            pseudo_lock_n_reg <= 1'b0;
            // Lock persists while the requester keeps it asserted
            lock_reg <= req_lock; // [RL12]
          end
        end
        default: state_reg <= LBC_IDLE;
      endcase
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      bus.word_address_lines_o <= 30'h0; bus.addr_oe <= 1'b0;
      bus.byte_lane_enables_n <= 4'hF; bus.be_oe <= 1'b0;
      bus.data_dev_o <= 32'h0; bus.data_dev_oe <= 1'b0; bus.parity_dev_o <= 4'h0;
      bus.cycle_type <= 3'h0; bus.address_strobe_n <= 1'b1; bus.ctl_oe <= 1'b0;
      bus.lock_n <= 1'b1; bus.pseudo_lock_n <= 1'b1; bus.last_burst_transfer_n <= 1'b1;
      bus.parity_error_status_n <= 1'b1; bus.hold_ack <= 1'b0;
      req_ready <= 1'b0; done_pulse <= 1'b0; rdata <= 32'h0; parity_bad <= 1'b0;
      inval_addr <= 30'h0; inval_valid <= 1'b0;
    end else if (clk_en) begin
      bus.hold_ack <= hold_reg;
      bus.addr_oe <= !hold_reg && !ah_s2; // [RL4]
      bus.be_oe <= !hold_reg; // [RL4]
      bus.ctl_oe <= !hold_reg;
      bus.word_address_lines_o <= addr_reg;
      bus.byte_lane_enables_n <= be_n_reg; // [RL2]
      bus.cycle_type <= type_reg; // [RL11]
      bus.address_strobe_n <= !(state_reg == LBC_FIRST) || hold_reg; // [RL19]
      bus.data_dev_o <= wdata_reg;
      bus.parity_dev_o <= wpar; // [RL6]
      bus.data_dev_oe <= !hold_reg && !is_read && state_reg != LBC_IDLE; // [RL5]
      bus.lock_n <= !lock_reg;
      bus.pseudo_lock_n <= !(pseudo_lock_n_reg || fpw_reg && first_reg); // [RL17]
      bus.last_burst_transfer_n <= pseudo_lock_n_reg && !(fpw_reg && first_reg); // [RL17]
      // Only enabled lanes can flag an error; no other side effect
      bus.parity_error_status_n <= !(check_reg && |(p_cap & ~be_n_reg)); // [RL8] [RL9] [RL10]
      parity_bad <= check_reg && |(p_cap & ~be_n_reg); // [RL10]
      req_ready <= state_reg == LBC_IDLE && !hold_reg;
      // Done only when the last cycle of a transfer ends, single-cycle or multi-cycle
      done_pulse <= rdy_ok && left_reg == 2'h0;
      rdata <= d_cap;
      inval_valid <= ah_s2 && !address_float_request_d; // [RL3]
      if (ah_s2 && !address_float_request_d) inval_addr <= {a_s2[29:`LBC_INVAL_LSB], 2'b00}; // [RL3]
    end
  end
endmodule

/* lbc_extern.sv */
`timescale 1ns/1ns
`include "lbc_consts.svh"
module lbc_extern
  import lbc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  lbc_if.ext bus,
  input wire logic [31:0] rd_data,
  input wire logic [3:0] rd_parity_flip,
  input wire logic [1:0] wait_states,
  input wire logic address_float_request_in,
  input wire logic [29:0] inval_addr_in,
  input wire logic hold_in,
  output logic [2:0] seen_type,
  output logic [29:0] seen_addr,
  output logic [31:0] seen_wdata,
  output logic seen_pulse,
  output logic seen_pseudo_lock_n,
  output logic perr_seen
);
  logic act_reg, st_d;
  logic [1:0] cnt_reg;
  logic [2:0] type_reg;
  logic [3:0] par;
  lbc_parity u_par (.data(rd_data), .parity(par));

  // ****************************************
  // Responder
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      act_reg <= 1'b0; cnt_reg <= 2'h0; type_reg <= 3'h0; st_d <= 1'b0;
      bus.ready_n <= 1'b1; bus.data_ext_o <= 32'h0; bus.data_ext_oe <= 1'b0;
      bus.parity_ext_o <= 4'h0; bus.word_address_lines_i <= 30'h0;
      bus.address_float_request <= 1'b0; bus.hold_req <= 1'b0;
      seen_type <= 3'h0; seen_addr <= 30'h0; seen_wdata <= 32'h0;
      seen_pulse <= 1'b0; seen_pseudo_lock_n <= 1'b0; perr_seen <= 1'b0;
    end else if (clk_en) begin
      seen_pulse <= 1'b0;
      bus.address_float_request <= address_float_request_in;
      bus.hold_req <= hold_in;
      bus.word_address_lines_i <= inval_addr_in; // [RL3]
      perr_seen <= !bus.parity_error_status_n;
      st_d <= !bus.address_strobe_n && bus.ctl_oe;
      bus.ready_n <= 1'b1;
      if (st_d && !act_reg) begin // [RL20]
        act_reg <= 1'b1;
        type_reg <= bus.cycle_type;
        cnt_reg <= wait_states;
        seen_type <= bus.cycle_type;
        seen_addr <= bus.word_address_lines_o;
      end else if (act_reg) begin
        if (cnt_reg != 2'h0) begin
          cnt_reg <= cnt_reg - 2'h1;
        end else if (bus.ready_n) begin
          bus.ready_n <= 1'b0; // [RL21] [RL22]
          bus.data_ext_o <= rd_data;
          bus.parity_ext_o <= par ^ rd_parity_flip; // [RL7]
          bus.data_ext_oe <= !type_reg[0];
        end else begin
          act_reg <= 1'b0;
          bus.data_ext_oe <= 1'b0;
          seen_wdata <= bus.data_bus_lines;
          seen_pseudo_lock_n <= !bus.pseudo_lock_n; // [RL18]
          seen_pulse <= 1'b1;
        end
      end
    end
  end
endmodule

/* lbc_monitor.sv */
`timescale 1ns/1ns
// ****
// Bus checker
// ****
module lbc_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic addr_oe,
  input wire logic be_oe,
  input wire logic data_dev_oe,
  input wire logic [31:0] data_dev_o,
  input wire logic [3:0] parity_dev_o,
  input wire logic [2:0] cycle_type,
  input wire logic address_strobe_n,
  input wire logic lock_n,
  input wire logic pseudo_lock_n,
  input wire logic ready_n,
  input wire logic parity_error_status_n,
  input wire logic address_float_request,
  input wire logic hold_ack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_strobe_one_clk: assert property (!address_strobe_n |=> address_strobe_n)
    else $error("strobe held past first clock");
  a_strobe_hold_off: assert property (hold_ack |-> address_strobe_n)
    else $error("strobe during bus hold");
  a_no_reserved_code: assert property (!address_strobe_n |-> cycle_type != 3'h5)
    else $error("reserved cycle code issued");
  a_write_even_parity: assert property (data_dev_oe |-> parity_dev_o ==
    {^data_dev_o[31:24], ^data_dev_o[23:16], ^data_dev_o[15:8], ^data_dev_o[7:0]})
    else $error("write parity not even");
  a_data_only_write: assert property (data_dev_oe |-> cycle_type[0])
    else $error("data driven outside a write");
  a_status_one_clk: assert property ($fell(parity_error_status_n) |=> parity_error_status_n)
    else $error("parity status longer than one clock");
  a_no_ready_first: assert property (!address_strobe_n |-> ready_n)
    else $error("ready in first clock of cycle");
  a_lock_no_hold: assert property (!lock_n |-> !hold_ack)
    else $error("hold granted under lock");
  a_pseudo_lock_n_no_hold: assert property (!pseudo_lock_n |-> !hold_ack)
    else $error("hold granted under pseudo-lock");
  a_hold_floats: assert property (hold_ack |-> !addr_oe && !be_oe && !data_dev_oe)
    else $error("bus driven during hold");
  a_address_float_request_floats: assert property (address_float_request [*4] |-> !addr_oe)
    else $error("address driven during address hold");
endmodule

/* cpu_local_bus_cycle_interface_tb.sv */
`timescale 1ns/1ns
`include "lbc_consts.svh"
module cpu_local_bus_cycle_interface_tb;
  import lbc_pkg::*;
  logic clk = 0;
  logic reset = 1;
  logic req_valid = 0;
  logic req_lock = 0;
  logic [2:0] req_type = 0;
  logic [29:0] req_addr = 0;
  logic [3:0] req_be_n = 0;
  logic [31:0] req_wdata = 0;
  logic [1:0] req_count = 0;
  logic [31:0] rd_data = 0;
  logic [3:0] rd_parity_flip = 0;
  logic [1:0] wait_states = 0;
  logic address_float_request_in = 0;
  logic hold_in = 0;
  logic [29:0] inval_addr_in = 0;
  logic req_ready, done_pulse, parity_bad, inval_valid;
  logic [31:0] rdata, seen_wdata;
  logic [29:0] inval_addr, seen_addr;
  logic [2:0] seen_type;
  logic pb_seen = 0;
  logic iv_seen = 0;
  logic pl_seen = 0;
  logic seen_pseudo_lock_n;
  logic ok;
  int miscompares = 0;
  int n_compared = 0;
  logic [31:0] exp_q[$];
  lbc_if bus_if();
  lbc_device lbc_device_i(.clk(clk), .reset(reset), .clk_en(1'b1), .bus(bus_if.dev),
    .req_valid(req_valid), .req_type(req_type), .req_addr(req_addr), .req_be_n(req_be_n),
    .req_wdata(req_wdata), .req_count(req_count), .req_lock(req_lock), .req_fp_write(1'b0),
    .req_ready(req_ready), .done_pulse(done_pulse), .rdata(rdata), .parity_bad(parity_bad),
    .inval_addr(inval_addr), .inval_valid(inval_valid));
  lbc_extern lbc_extern_i(.clk(clk), .reset(reset), .clk_en(1'b1), .bus(bus_if.ext),
    .rd_data(rd_data), .rd_parity_flip(rd_parity_flip), .wait_states(wait_states),
    .address_float_request_in(address_float_request_in), .inval_addr_in(inval_addr_in), .hold_in(hold_in),
    .seen_type(seen_type), .seen_addr(seen_addr), .seen_wdata(seen_wdata), .seen_pulse(),
    .seen_pseudo_lock_n(seen_pseudo_lock_n), .perr_seen());
  lbc_monitor lbc_monitor_i(.clk(clk), .reset(reset), .addr_oe(bus_if.addr_oe),
    .be_oe(bus_if.be_oe), .data_dev_oe(bus_if.data_dev_oe), .data_dev_o(bus_if.data_dev_o),
    .parity_dev_o(bus_if.parity_dev_o), .cycle_type(bus_if.cycle_type),
    .address_strobe_n(bus_if.address_strobe_n), .lock_n(bus_if.lock_n),
    .pseudo_lock_n(bus_if.pseudo_lock_n), .ready_n(bus_if.ready_n),
    .parity_error_status_n(bus_if.parity_error_status_n),
    .address_float_request(bus_if.address_float_request), .hold_ack(bus_if.hold_ack));
  // ****
  // Clock, pulse catchers, checks
  // ****
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (parity_bad === 1'b1) pb_seen <= 1'b1;
    if (inval_valid === 1'b1) iv_seen <= 1'b1;
    if (seen_pseudo_lock_n === 1'b1) pl_seen <= 1'b1;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task wait_done(input int n);
    ok = 0;
    for (int i = 0; i < n && !ok; i++) begin
      @(negedge clk);
      ok = (done_pulse === 1'b1);
    end
  endtask
  task op(input logic [2:0] t, input logic lk, input logic [1:0] cnt, input logic [3:0] flip);
    logic [29:0] a;
    logic rd;
    a = $urandom;
    rd = (t == 3'h0 || t == 3'h2 || t == 3'h4 || t == 3'h6);
    for (int i = 0; i < 60 && req_ready !== 1'b1; i++) @(negedge clk);
    chk(req_ready, 1, "accept");
    req_type = t;
    req_addr = a;
    req_be_n = $urandom;
    req_wdata = $urandom;
    req_count = cnt;
    req_lock = lk;
    rd_data = $urandom;
    rd_parity_flip = flip;
    wait_states = $urandom;
    pb_seen = 0;
    pl_seen = 0;
    exp_q.push_back(rd ? rd_data : req_wdata);
    req_valid = 1;
    @(negedge clk);
    req_valid = 0;
    wait_done(80);
    chk(ok, 1, "done");
    repeat (4) @(negedge clk);
    chk(seen_type, t, "type");
    if (!t[2]) a = a & `LBC_IO_ADDR_MAX;
    chk(seen_addr, 30'(a + cnt), "addr");
    if (rd) chk(rdata, exp_q.pop_front(), "rdata");
    else chk(seen_wdata, exp_q.pop_front(), "wdata");
    chk(pb_seen, rd && t != 3'h0 && |(flip & ~req_be_n), "parity");
    chk(pl_seen, cnt != 2'h0 && !lk, "pseudo_lock_n");
  endtask
  task wrap_up;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(32'h4495));
    repeat (10) @(negedge clk);
    reset = 0;
    repeat (3) @(negedge clk);
    for (int t = 0; t < 8; t++) if (t != 5 && t != 1) op(t[2:0], 0, 0, $urandom);
    hold_in = 1;
    op(3'h6, 1, 0, 4'hF);
    op(3'h7, 1, 0, 4'h0);
    req_lock = 0;
    for (int i = 0; i < 40 && bus_if.hold_ack !== 1'b1; i++) @(negedge clk);
    chk(bus_if.hold_ack, 1, "hold");
    hold_in = 0;
    op(3'h6, 0, 1, 4'h0);
    op(3'h7, 0, 1, 4'h0);
    inval_addr_in = $urandom;
    address_float_request_in = 1;
    iv_seen = 0;
    repeat (20) @(negedge clk);
    chk(iv_seen, 1, "inval seen");
    chk(inval_addr, {inval_addr_in[29:2], 2'b00}, "inval addr");
    address_float_request_in = 0;
    repeat (5) @(negedge clk);
    req_type = 3'h5;
    req_valid = 1;
    wait_done(30);
    chk(ok, 0, "reserved");
    req_valid = 0;
    wrap_up;
  end
  initial begin
    #500000;
    miscompares++;
    wrap_up;
  end
endmodule
